// [shared/odec_map.svh]
// Address windows and field widths of the on-chip memory decoder.
`ifndef ODEC_MAP_SVH
`define ODEC_MAP_SVH

`define ODEC_ADDR_W 16
`define ODEC_BLK_OFS_W 8
`define ODEC_PWD_OFS_W 2
`define ODEC_ZERO_ADDR 16'h0000

`define ODEC_BOOT_LO 16'h0000
`define ODEC_BOOT_HI 16'h00ff
`define ODEC_PWD_LO 16'h0040
`define ODEC_PWD_HI 16'h0043

`define ODEC_PB0_LO 16'hfe00
`define ODEC_PB0_ALIAS_HI 16'hfeff
`define ODEC_PB0_HI 16'hffff

`define ODEC_DB0_LO 16'h0100
`define ODEC_DB0_ALIAS_HI 16'h01ff
`define ODEC_DB0_HI 16'h02ff

`define ODEC_DB1_LO 16'h0300
`define ODEC_DB1_ALIAS_LO 16'h0400
`define ODEC_DB1_HI 16'h04ff

`endif

// [shared/odec_pkg.sv]
// Types shared by the on-chip memory decoder.
`default_nettype none

package odec_pkg;

  // Target of a decoded access, one-hot.
  typedef enum logic [5:0] {
    ODEC_TGT_NONE = 6'h01,
    ODEC_TGT_BOOT = 6'h02,
    ODEC_TGT_MAIN = 6'h04,
    ODEC_TGT_PWD = 6'h08,
    ODEC_TGT_BLK0 = 6'h10,
    ODEC_TGT_BLK1 = 6'h20
  } odec_tgt_e;

endpackage

`default_nettype wire

// [rtl/odec_window.sv]
// Inclusive address window comparator.
`timescale 1ns/1ps
`default_nettype none

module odec_window #(
  parameter int AW = 16,
  parameter logic [AW-1:0] LO = '0,
  parameter logic [AW-1:0] HI = '1
) (
  // Address under test
  input wire logic [AW-1:0] addr,
  // Match
  output logic hit
);

  assign hit = (addr >= LO) && (addr <= HI);

endmodule

`default_nettype wire

// [rtl/odec_top.sv]
// On-chip memory address decoder for program and data spaces.
`timescale 1ns/1ps
`default_nettype none
`include "odec_map.svh"

module odec_top #(
  parameter int AW = `ODEC_ADDR_W,
  parameter int OW = `ODEC_BLK_OFS_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration from the core
  input wire logic boot_rom_enable,
  input wire logic block_zero_space_select,
  // Program-space request
  input wire logic prog_req,
  input wire logic prog_we,
  input wire logic [AW-1:0] prog_addr,
  // Data-space request
  input wire logic data_req,
  input wire logic data_we,
  input wire logic [AW-1:0] data_addr,
  // Program-space decode result
  output odec_pkg::odec_tgt_e prog_tgt,
  output logic [AW-1:0] prog_ofs,
  output logic prog_wr,
  output logic prog_alias,
  // Data-space decode result
  output odec_pkg::odec_tgt_e data_tgt,
  output logic [AW-1:0] data_ofs,
  output logic data_wr,
  output logic data_alias
);
  import odec_pkg::*;

  logic boot_hit, pwd_hit, pb0_hit, pb0_alias_hit;
  logic db0_hit, db0_alias_hit, db1_hit, db1_alias_hit;
  odec_tgt_e next_prog_tgt, next_data_tgt;
  logic [AW-1:0] next_prog_ofs, next_data_ofs;
  logic next_prog_wr, next_data_wr, next_prog_alias, next_data_alias;

  odec_window #(.AW(AW), .LO(`ODEC_BOOT_LO), .HI(`ODEC_BOOT_HI)) u_boot (
    .addr(prog_addr),
    .hit(boot_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_PWD_LO), .HI(`ODEC_PWD_HI)) u_pwd (
    .addr(prog_addr),
    .hit(pwd_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_PB0_LO), .HI(`ODEC_PB0_HI)) u_pb0 (
    .addr(prog_addr),
    .hit(pb0_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_PB0_LO), .HI(`ODEC_PB0_ALIAS_HI))
    u_pb0_alias (
    .addr(prog_addr),
    .hit(pb0_alias_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_DB0_LO), .HI(`ODEC_DB0_HI)) u_db0 (
    .addr(data_addr),
    .hit(db0_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_DB0_LO), .HI(`ODEC_DB0_ALIAS_HI))
    u_db0_alias (
    .addr(data_addr),
    .hit(db0_alias_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_DB1_LO), .HI(`ODEC_DB1_HI)) u_db1 (
    .addr(data_addr),
    .hit(db1_hit)
  );
  odec_window #(.AW(AW), .LO(`ODEC_DB1_ALIAS_LO), .HI(`ODEC_DB1_HI))
    u_db1_alias (
    .addr(data_addr),
    .hit(db1_alias_hit)
  );

  // Program space. The boot window covers the password words, so the
  // boot ROM wins there while it is enabled.
  always_comb begin
    next_prog_tgt = ODEC_TGT_NONE;
    next_prog_ofs = `ODEC_ZERO_ADDR;
    next_prog_wr = 1'b0;
    next_prog_alias = 1'b0;
    if (prog_req) begin
      if (boot_rom_enable && boot_hit) begin
        next_prog_tgt = ODEC_TGT_BOOT;
        next_prog_ofs = {{(AW-OW){1'b0}}, prog_addr[OW-1:0]};
      end else if (pwd_hit) begin
        // Password words are never written through the normal path.
        next_prog_tgt = ODEC_TGT_PWD;
        next_prog_ofs = {{(AW-`ODEC_PWD_OFS_W){1'b0}},
                         prog_addr[`ODEC_PWD_OFS_W-1:0]};
      end else if (block_zero_space_select && pb0_hit) begin
        // Both halves fold onto the same 256 words.
        next_prog_tgt = ODEC_TGT_BLK0;
        next_prog_ofs = {{(AW-OW){1'b0}}, prog_addr[OW-1:0]};
        next_prog_wr = prog_we;
        next_prog_alias = pb0_alias_hit;
      end else begin
        next_prog_tgt = ODEC_TGT_MAIN;
        next_prog_ofs = prog_addr;
        next_prog_wr = prog_we;
      end
    end
  end

  // Data space. Addresses outside both blocks belong to other logic.
  always_comb begin
    next_data_tgt = ODEC_TGT_NONE;
    next_data_ofs = `ODEC_ZERO_ADDR;
    next_data_wr = 1'b0;
    next_data_alias = 1'b0;
    if (data_req) begin
      if (!block_zero_space_select && db0_hit) begin
        next_data_tgt = ODEC_TGT_BLK0;
        next_data_ofs = {{(AW-OW){1'b0}}, data_addr[OW-1:0]};
        next_data_wr = data_we;
        next_data_alias = db0_alias_hit;
      end else if (db1_hit) begin
        next_data_tgt = ODEC_TGT_BLK1;
        next_data_ofs = {{(AW-OW){1'b0}}, data_addr[OW-1:0]};
        next_data_wr = data_we;
        next_data_alias = db1_alias_hit;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prog_tgt <= ODEC_TGT_NONE;
      prog_ofs <= `ODEC_ZERO_ADDR;
      prog_wr <= 1'b0;
      prog_alias <= 1'b0;
    end else begin
      prog_tgt <= next_prog_tgt;
      prog_ofs <= next_prog_ofs;
      prog_wr <= next_prog_wr;
      prog_alias <= next_prog_alias;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_tgt <= ODEC_TGT_NONE;
      data_ofs <= `ODEC_ZERO_ADDR;
      data_wr <= 1'b0;
      data_alias <= 1'b0;
    end else begin
      data_tgt <= next_data_tgt;
      data_ofs <= next_data_ofs;
      data_wr <= next_data_wr;
      data_alias <= next_data_alias;
    end
  end

  a_boot_claims_low: assert property (
    @(posedge mclk) disable iff (sys_rst)
    prog_req && boot_rom_enable && prog_addr <= `ODEC_BOOT_HI
    |=> prog_tgt == ODEC_TGT_BOOT && !prog_wr
  ) else $error("boot window not routed to boot ROM");

  a_boot_off_pwd: assert property (
    @(posedge mclk) disable iff (sys_rst)
    prog_req && !boot_rom_enable && prog_addr >= `ODEC_PWD_LO
      && prog_addr <= `ODEC_PWD_HI
    |=> prog_tgt == ODEC_TGT_PWD && !prog_wr
      && prog_ofs == $past(prog_addr) - `ODEC_PWD_LO
  ) else $error("password word not reserved");

  a_pwd_only_there: assert property (
    @(posedge mclk) disable iff (sys_rst)
    prog_tgt == ODEC_TGT_PWD
    |-> $past(prog_addr) >= `ODEC_PWD_LO && $past(prog_addr) <= `ODEC_PWD_HI
  ) else $error("password target outside its words");

  a_prog_blk0_fold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    prog_req && block_zero_space_select && prog_addr >= `ODEC_PB0_LO
    |=> prog_tgt == ODEC_TGT_BLK0
      && prog_ofs == {8'h00, $past(prog_addr[7:0])}
      && prog_alias == ($past(prog_addr) <= `ODEC_PB0_ALIAS_HI)
  ) else $error("program block zero folding wrong");

  a_data_blk0_fold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    data_req && !block_zero_space_select && data_addr >= `ODEC_DB0_LO
      && data_addr <= `ODEC_DB0_HI
    |=> data_tgt == ODEC_TGT_BLK0 && data_wr == $past(data_we)
      && data_ofs == {8'h00, $past(data_addr[7:0])}
  ) else $error("data block zero folding wrong");

  a_data_blk1_fold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    data_req && data_addr >= `ODEC_DB1_LO && data_addr <= `ODEC_DB1_HI
    |=> data_tgt == ODEC_TGT_BLK1
      && data_ofs == {8'h00, $past(data_addr[7:0])}
      && data_alias == ($past(data_addr) >= `ODEC_DB1_ALIAS_LO)
  ) else $error("block one folding wrong");

  a_blk0_one_space: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(prog_tgt == ODEC_TGT_BLK0 && data_tgt == ODEC_TGT_BLK0)
  ) else $error("block zero answers in both spaces");

  a_blk0_follows_sel: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (prog_tgt == ODEC_TGT_BLK0 |-> $past(block_zero_space_select))
      and (data_tgt == ODEC_TGT_BLK0 |-> !$past(block_zero_space_select))
  ) else $error("block zero answers in the unselected space");

  a_idle_no_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !prog_req && !data_req
    |=> prog_tgt == ODEC_TGT_NONE && data_tgt == ODEC_TGT_NONE
      && !prog_wr && !data_wr
  ) else $error("decode without request");

endmodule

`default_nettype wire

// [tb/odec_core_model.sv]
// Processor core model that presents program and data accesses.
`timescale 1ns/1ps
`default_nettype none

module odec_core_model (
  // Clock
  input wire logic mclk,
  // Configuration
  output logic boot_rom_enable,
  output logic block_zero_space_select,
  // Program-space request
  output logic prog_req,
  output logic prog_we,
  output logic [15:0] prog_addr,
  // Data-space request
  output logic data_req,
  output logic data_we,
  output logic [15:0] data_addr
);
  initial begin
    {boot_rom_enable, block_zero_space_select} = 2'b00;
    {prog_req, prog_we, data_req, data_we} = 4'h0;
    prog_addr = 16'h0000;
    data_addr = 16'h0000;
  end

  // The core may issue every cycle, so each call owns exactly one cycle.
  // Config moves with the request because the decoder samples both together.
  task automatic issue(input logic [1:0] cfg, input logic [1:0] pq,
      input logic [15:0] pa, input logic [1:0] dq, input logic [15:0] da);
    @(posedge mclk);
    #1;
    {boot_rom_enable, block_zero_space_select} = cfg;
    {prog_req, prog_we} = pq;
    prog_addr = pa;
    {data_req, data_we} = dq;
    data_addr = da;
  endtask
endmodule
`default_nettype wire

// [tb/onchip_memory_address_decoder_tb.sv]
// Self-checking bench for the on-chip memory address decoder.
`timescale 1ns/1ps
`default_nettype none

module onchip_memory_address_decoder_tb;
  import odec_pkg::*;
  logic mclk, sys_rst, boot_rom_enable, block_zero_space_select;
  logic prog_req, prog_we, data_req, data_we, prog_wr, prog_alias;
  logic data_wr, data_alias;
  logic [15:0] prog_addr, data_addr, prog_ofs, data_ofs, pa, da;
  odec_tgt_e prog_tgt, data_tgt;
  int err_count = 0;
  int samples_checked = 0;
  logic [23:0] idle = {ODEC_TGT_NONE, 16'h0000, 2'b00};
  logic [23:0] exp_p, exp_d;
  logic [15:0] corners [12] = '{16'h003f, 16'h0043, 16'h0044, 16'h00ff,
    16'h0100, 16'h01ff, 16'h02ff, 16'h0300, 16'h04ff, 16'h0500,
    16'hfeff, 16'hff00};
  logic [15:0] bases [8] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300,
    16'h0400, 16'hfe00, 16'hff00, 16'h8000};

  odec_core_model core_u (.mclk(mclk), .boot_rom_enable(boot_rom_enable),
    .block_zero_space_select(block_zero_space_select),
    .prog_req(prog_req), .prog_we(prog_we), .prog_addr(prog_addr),
    .data_req(data_req), .data_we(data_we), .data_addr(data_addr));

  odec_top dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .boot_rom_enable(boot_rom_enable),
    .block_zero_space_select(block_zero_space_select),
    .prog_req(prog_req), .prog_we(prog_we), .prog_addr(prog_addr),
    .data_req(data_req), .data_we(data_we), .data_addr(data_addr),
    .prog_tgt(prog_tgt), .prog_ofs(prog_ofs), .prog_wr(prog_wr),
    .prog_alias(prog_alias), .data_tgt(data_tgt), .data_ofs(data_ofs),
    .data_wr(data_wr), .data_alias(data_alias));

  function automatic logic [23:0] exp_prog(logic [1:0] c, logic [1:0] q,
      logic [15:0] a);
    if (!q[1]) return {ODEC_TGT_NONE, 16'h0000, 2'b00};
    if (c[1] && a <= 16'h00ff)
      return {ODEC_TGT_BOOT, 8'h00, a[7:0], 2'b00};
    if (a >= 16'h0040 && a <= 16'h0043)
      return {ODEC_TGT_PWD, 14'h0000, a[1:0], 2'b00};
    if (c[0] && a >= 16'hfe00)
      return {ODEC_TGT_BLK0, 8'h00, a[7:0], q[0], a < 16'hff00};
    return {ODEC_TGT_MAIN, a, q[0], 1'b0};
  endfunction

  function automatic logic [23:0] exp_data(logic [1:0] c, logic [1:0] q,
      logic [15:0] a);
    if (q[1] && !c[0] && a >= 16'h0100 && a <= 16'h02ff)
      return {ODEC_TGT_BLK0, 8'h00, a[7:0], q[0], a < 16'h0200};
    if (q[1] && a >= 16'h0300 && a <= 16'h04ff)
      return {ODEC_TGT_BLK1, 8'h00, a[7:0], q[0], a >= 16'h0400};
    return {ODEC_TGT_NONE, 16'h0000, 2'b00};
  endfunction

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each step checks the answer to the previous request, then queues the
  // expectation for this one; a reset request forces the idle answer.
  task automatic step(input logic r, input logic [1:0] c,
      input logic [1:0] pq, input logic [15:0] a, input logic [1:0] dq,
      input logic [15:0] d);
    core_u.issue(c, pq, a, dq, d);
    sys_rst = r;
    chk({prog_tgt, prog_ofs, prog_wr, prog_alias}, exp_p);
    chk({data_tgt, data_ofs, data_wr, data_alias}, exp_d);
    exp_p = r ? idle : exp_prog(c, pq, a);
    exp_d = r ? idle : exp_data(c, dq, d);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #(6000 * 50);
    err_count++;
    end_of_test();
  end

  initial begin
    sys_rst = 1'b1;
    exp_p = idle;
    exp_d = idle;
    void'($urandom(32'h28e6));
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 48; i++) begin
      step(1'b0, 2'(i % 4), {1'b1, i[2]}, corners[i / 4],
        {1'b1, i[3]}, corners[11 - i / 4]);
    end
    for (int i = 0; i < 3000; i++) begin
      pa = bases[$urandom_range(7)] | 16'($urandom_range(255));
      da = bases[$urandom_range(7)] | 16'($urandom_range(255));
      if (i % 7 == 0) pa = 16'h0040 | 16'($urandom_range(3));
      if (i == 1500) step(1'b1, 2'b01, 2'b11, 16'hff10, 2'b11, 16'h0310);
      step(1'b0, 2'($urandom), 2'($urandom), pa, 2'($urandom), da);
    end
    step(1'b0, 2'b00, 2'b00, 16'h0000, 2'b00, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
